// ===== rtl/plc_pkg.sv
// Package for the loop configuration control block: register map, field layout, resets.
// Assumes a classic Wishbone slave with 32-bit data and byte addresses.
package plc_pkg;
    localparam int          ADDR_W          = 8;
    localparam logic [7:0]  OFF_LOOP1       = 8'h00;
    localparam logic [7:0]  OFF_CTRL        = 8'h04;
    localparam logic [7:0]  OFF_FILTER      = 8'h08;
    localparam logic [7:0]  OFF_STATUS      = 8'h0c;
    // Loop one word
    localparam int          POS_PUMP_CUR    = 0;
    localparam int          POS_PUMP_POL    = 3;
    // Control word, global enable kept at b18 as in the device word
    localparam int          POS_XTAL_EN     = 0;
    localparam int          POS_AUX_EN      = 1;
    localparam int          POS_SLEEP       = 2;
    localparam int          POS_DOUBLER     = 3;
    localparam int          POS_GLOBAL_EN   = 18;
    // Filter word
    localparam int          POS_RES3        = 0;
    localparam int          POS_RES4        = 4;
    localparam int          POS_CAP         = 8;
    // Status word
    localparam int          POS_ST_CODE_BAD = 0;
    localparam int          POS_ST_CLK_ON   = 1;
    localparam int          POS_ST_AWAKE    = 2;
    // Reset values
    localparam logic [2:0]  RST_PUMP_CUR    = 3'h2;
    localparam logic        RST_PUMP_POL    = 1'b0;
    localparam logic        RST_XTAL_EN     = 1'b0;
    localparam logic        RST_AUX_EN      = 1'b0;
    localparam logic        RST_GLOBAL_EN   = 1'b1;
    localparam logic        RST_SLEEP       = 1'b0;
    localparam logic        RST_DOUBLER     = 1'b0;
    localparam logic [2:0]  RST_RES         = 3'h0;
    localparam logic [3:0]  RST_CAP         = 4'h0;
    // Code limits
    localparam logic [2:0]  PUMP_MIN_CODE   = 3'h2;
    localparam logic [2:0]  RES_MAX_CODE    = 3'h4;
    localparam logic [3:0]  CAP_MAX_CODE    = 4'hb;
    // Decoded pump current in microamps, indexed by code
    typedef logic [8:0] plc_ua_t;
    typedef enum logic [1:0] {
        PLC_IDLE = 2'b00,
        PLC_ACK  = 2'b01
    } plc_state_t;
endpackage : plc_pkg

// ===== rtl/plc_loop_config.sv
// Loop configuration and control registers behind a Wishbone slave.
// Assumes synchronous inputs on ref_clk and a classic single-cycle master.
// What this block does
// - The 3-bit pump current code picks 20, 80, 25, 50, 100 or 400 uA, codes 0 and 1 reserved.
// - Pump polarity 0 suits a negative-slope oscillator and 1 a positive-slope one.
// - The crystal amplifier enable turns the oscillator amplifier off at 0 and on at 1.
// - The auxiliary output enable gates the auxiliary output and resets to 0.
// - The global output enable sits at bit 18 of the control word, is writable, resets to 1.
// - Global enable 0 stops all output clocks on top of the external output enable pin.
// - Sleep at 1 cuts the pump current and every enable, overriding the other enable bits and the pin.
// - Doubler enable routes the loop two reference past its divider through a doubler.
// - Resistor three codes 0 to 4 pick below 600 ohm up to 40 kohm, 5 to 7 invalid.
// - Resistor four codes 0 to 4 pick below 200 ohm up to 40 kohm, 5 to 7 invalid.
// - Capacitor codes 0 to 11 pick twelve capacitor pairs, 12 to 15 reserved.
`timescale 1ns/1ps
module plc_loop_config
(
    input  wire logic                      ref_clk,
    input  wire logic                      srst,
    input  wire logic                      wb_cyc_i,
    input  wire logic                      wb_stb_i,
    input  wire logic                      wb_we_i,
    input  wire logic [plc_pkg::ADDR_W-1:0] wb_adr_i,
    input  wire logic [31:0]               wb_dat_i,
    input  wire logic [3:0]                wb_sel_i,
    output logic      [31:0]               wb_dat_o,
    output logic                           wb_ack_o,
    input  wire logic                      output_enable_pin,
    output logic      [2:0]                loop1_pump_current_sel,
    output logic      [8:0]                loop1_pump_ua,
    output logic                           loop1_pump_polarity,
    output logic                           crystal_amp_enable,
    output logic                           aux_out_enable,
    output logic                           out_clocks_run,
    output logic                           device_sleep,
    output logic                           ref_doubler_enable,
    output logic                           loop2_div_bypass,
    output logic      [2:0]                filter_res_three_sel,
    output logic      [2:0]                filter_res_four_sel,
    output logic      [3:0]                filter_cap_pair_sel,
    output logic                           code_invalid
);
    import plc_pkg::*;

    plc_state_t state;
    logic       pump_pol_r;
    logic [2:0] pump_cur_r;
    logic       xtal_r;
    logic       aux_r;
    logic       glob_r;
    logic       sleep_r;
    logic       dbl_r;
    logic [2:0] res3_r;
    logic [2:0] res4_r;
    logic [3:0] cap_r;
    logic       req;
    logic       wr;
    logic       bad_code;
    logic [31:0] rd_word;
    plc_ua_t    next_ua;

    assign req = wb_cyc_i && wb_stb_i && (state == PLC_IDLE);
    assign wr  = req && wb_we_i;

    // One wait-free cycle: ack in the cycle after the request, then drop for a cycle
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            state    <= PLC_IDLE;
            wb_ack_o <= 1'b0;
        end else begin
            case (state)
                PLC_IDLE: begin
                    wb_ack_o <= req;
                    if (req) begin
                        state <= PLC_ACK;
                    end
                end
                PLC_ACK: begin
                    wb_ack_o <= 1'b0;
                    state    <= PLC_IDLE;
                end
                default: begin
                    wb_ack_o <= 1'b0;
                    state    <= PLC_IDLE;
                end
            endcase
        end
    end

    // Loop one word
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            pump_cur_r <= RST_PUMP_CUR;
            pump_pol_r <= RST_PUMP_POL;
        end else if (wr && wb_adr_i == OFF_LOOP1 && wb_sel_i[0]) begin
            pump_cur_r <= wb_dat_i[POS_PUMP_CUR +: 3];
            pump_pol_r <= wb_dat_i[POS_PUMP_POL];
        end
    end

    // Control word; b18 lives in byte lane 2
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            xtal_r  <= RST_XTAL_EN;
            aux_r   <= RST_AUX_EN;
            sleep_r <= RST_SLEEP;
            dbl_r   <= RST_DOUBLER;
            glob_r  <= RST_GLOBAL_EN;
        end else if (wr && wb_adr_i == OFF_CTRL) begin
            if (wb_sel_i[0]) begin
                xtal_r  <= wb_dat_i[POS_XTAL_EN];
                aux_r   <= wb_dat_i[POS_AUX_EN];
                sleep_r <= wb_dat_i[POS_SLEEP];
                dbl_r   <= wb_dat_i[POS_DOUBLER];
            end
            if (wb_sel_i[2]) begin
                glob_r <= wb_dat_i[POS_GLOBAL_EN];
            end
        end
    end

    // Filter word
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            res3_r <= RST_RES;
            res4_r <= RST_RES;
            cap_r  <= RST_CAP;
        end else if (wr && wb_adr_i == OFF_FILTER) begin
            if (wb_sel_i[0]) begin
                res3_r <= wb_dat_i[POS_RES3 +: 3];
                res4_r <= wb_dat_i[POS_RES4 +: 3];
            end
            if (wb_sel_i[1]) begin
                cap_r <= wb_dat_i[POS_CAP +: 4];
            end
        end
    end

    // Reserved codes are flagged, not corrected; the analog response to them is undefined
    assign bad_code = (pump_cur_r < PUMP_MIN_CODE) || (res3_r > RES_MAX_CODE)
                    || (res4_r > RES_MAX_CODE) || (cap_r > CAP_MAX_CODE);

    always_comb begin
        case (pump_cur_r)
            3'h2:    next_ua = 9'h014;
            3'h3:    next_ua = 9'h050;
            3'h4:    next_ua = 9'h019;
            3'h5:    next_ua = 9'h032;
            3'h6:    next_ua = 9'h064;
            3'h7:    next_ua = 9'h190;
            default: next_ua = 9'h000;
        endcase
    end

    always_comb begin
        rd_word = 32'h0000_0000;
        case (wb_adr_i)
            OFF_LOOP1: begin
                rd_word[POS_PUMP_CUR +: 3] = pump_cur_r;
                rd_word[POS_PUMP_POL]      = pump_pol_r;
            end
            OFF_CTRL: begin
                rd_word[POS_XTAL_EN]   = xtal_r;
                rd_word[POS_AUX_EN]    = aux_r;
                rd_word[POS_SLEEP]     = sleep_r;
                rd_word[POS_DOUBLER]   = dbl_r;
                rd_word[POS_GLOBAL_EN] = glob_r;
            end
            OFF_FILTER: begin
                rd_word[POS_RES3 +: 3] = res3_r;
                rd_word[POS_RES4 +: 3] = res4_r;
                rd_word[POS_CAP +: 4]  = cap_r;
            end
            OFF_STATUS: begin
                rd_word[POS_ST_CODE_BAD] = code_invalid;
                rd_word[POS_ST_CLK_ON]   = out_clocks_run;
                rd_word[POS_ST_AWAKE]    = ~device_sleep;
            end
            default: rd_word = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_dat_o <= req ? rd_word : 32'h0000_0000;
        end
    end

    // Loop one outputs; the code stays visible in sleep, only the current is cut
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            loop1_pump_current_sel <= RST_PUMP_CUR;
            loop1_pump_ua          <= 9'h000;
            loop1_pump_polarity    <= RST_PUMP_POL;
        end else begin
            loop1_pump_current_sel <= pump_cur_r;
            loop1_pump_ua          <= sleep_r ? 9'h000 : next_ua;
            loop1_pump_polarity    <= pump_pol_r;
        end
    end

    // Sleep forces every enable to its off state, whatever the pin and the other bits say
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            crystal_amp_enable <= RST_XTAL_EN;
            aux_out_enable     <= RST_AUX_EN;
            out_clocks_run     <= 1'b0;
            device_sleep       <= RST_SLEEP;
            ref_doubler_enable <= RST_DOUBLER;
            loop2_div_bypass   <= RST_DOUBLER;
        end else begin
            crystal_amp_enable <= xtal_r && !sleep_r;
            aux_out_enable     <= aux_r && !sleep_r;
            out_clocks_run     <= glob_r && output_enable_pin && !sleep_r;
            device_sleep       <= sleep_r;
            ref_doubler_enable <= dbl_r && !sleep_r;
            loop2_div_bypass   <= dbl_r && !sleep_r;
        end
    end

    // Filter selections are plain copies; invalid codes pass and only raise the flag
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            filter_res_three_sel <= RST_RES;
            filter_res_four_sel  <= RST_RES;
            filter_cap_pair_sel  <= RST_CAP;
        end else begin
            filter_res_three_sel <= res3_r;
            filter_res_four_sel  <= res4_r;
            filter_cap_pair_sel  <= cap_r;
        end
    end

    // Flag lags the fields by one cycle like every other output
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            code_invalid <= 1'b0;
        end else begin
            code_invalid <= bad_code;
        end
    end

    // Bus handshake: one answer a cycle after the request, data only with it
    chk_ack_answer: assert property (@(posedge ref_clk) disable iff (srst)
        wb_cyc_i && wb_stb_i && state == PLC_IDLE |=> wb_ack_o)
        else $error("request not answered in one cycle");
    chk_ack_once: assert property (@(posedge ref_clk) disable iff (srst)
        wb_ack_o |=> !wb_ack_o)
        else $error("ack held two cycles");
    chk_ack_data: assert property (@(posedge ref_clk) disable iff (srst)
        !wb_ack_o |-> wb_dat_o == 32'h0000_0000)
        else $error("read data driven without ack");

    // Loop one pump magnitude and polarity
    chk_pump_rsv: assert property (@(posedge ref_clk) disable iff (srst)
        pump_cur_r < PUMP_MIN_CODE |=> loop1_pump_ua == 9'h000 && code_invalid)
        else $error("reserved pump code not flagged");
    chk_pump_three: assert property (@(posedge ref_clk) disable iff (srst)
        pump_cur_r == 3'h3 && !sleep_r |=> loop1_pump_ua == 9'h050)
        else $error("pump code 3 not 80 uA");
    chk_pump_four: assert property (@(posedge ref_clk) disable iff (srst)
        pump_cur_r == 3'h4 && !sleep_r |=> loop1_pump_ua == 9'h019)
        else $error("pump code 4 not 25 uA");
    chk_pump_five: assert property (@(posedge ref_clk) disable iff (srst)
        pump_cur_r == 3'h5 && !sleep_r |=> loop1_pump_ua == 9'h032)
        else $error("pump code 5 not 50 uA");
    chk_pump_six: assert property (@(posedge ref_clk) disable iff (srst)
        pump_cur_r == 3'h6 && !sleep_r |=> loop1_pump_ua == 9'h064)
        else $error("pump code 6 not 100 uA");
    chk_pump_top: assert property (@(posedge ref_clk) disable iff (srst)
        pump_cur_r == 3'h7 && !sleep_r |=> loop1_pump_ua == 9'h190)
        else $error("pump code 7 not 400 uA");
    chk_code_copy: assert property (@(posedge ref_clk) disable iff (srst)
        1'b1 |=> loop1_pump_current_sel == $past(pump_cur_r))
        else $error("pump code output does not follow the field");
    chk_pol_follow: assert property (@(posedge ref_clk) disable iff (srst)
        1'b1 |=> loop1_pump_polarity == $past(pump_pol_r))
        else $error("polarity output does not follow the field");

    // Control word enables, global gate and sleep override
    chk_xtal_on: assert property (@(posedge ref_clk) disable iff (srst)
        xtal_r && !sleep_r |=> crystal_amp_enable)
        else $error("crystal amp not on");
    chk_xtal_off: assert property (@(posedge ref_clk) disable iff (srst)
        !xtal_r |=> !crystal_amp_enable)
        else $error("crystal amp on while its bit is low");
    chk_aux_on: assert property (@(posedge ref_clk) disable iff (srst)
        aux_r && !sleep_r |=> aux_out_enable)
        else $error("aux output not enabled");
    chk_aux_off: assert property (@(posedge ref_clk) disable iff (srst)
        !aux_r |=> !aux_out_enable)
        else $error("aux output enabled while its bit is low");
    chk_aux_reset: assert property (@(posedge ref_clk) disable iff (srst)
        $fell(srst) |-> !aux_r)
        else $error("aux enable not low after reset");
    chk_glob_write: assert property (@(posedge ref_clk) disable iff (srst)
        wr && wb_adr_i == OFF_CTRL && wb_sel_i[2] |=> glob_r == $past(wb_dat_i[POS_GLOBAL_EN]))
        else $error("global enable not at bit 18");
    chk_glob_reset: assert property (@(posedge ref_clk) disable iff (srst)
        $fell(srst) |-> glob_r)
        else $error("global enable not high after reset");
    chk_clk_gate: assert property (@(posedge ref_clk) disable iff (srst)
        !glob_r |=> !out_clocks_run)
        else $error("clocks run with global enable low");
    chk_clk_run: assert property (@(posedge ref_clk) disable iff (srst)
        !srst && glob_r && output_enable_pin && !sleep_r |=> out_clocks_run)
        else $error("clocks stopped with every enable high");
    chk_pin_gate: assert property (@(posedge ref_clk) disable iff (srst)
        !output_enable_pin |=> !out_clocks_run)
        else $error("clocks run with the enable pin low");
    chk_sleep_over: assert property (@(posedge ref_clk) disable iff (srst)
        sleep_r |=> !crystal_amp_enable && !aux_out_enable && !ref_doubler_enable
        && !loop2_div_bypass && !out_clocks_run && loop1_pump_ua == 9'h000)
        else $error("sleep did not override outputs");
    chk_sleep_show: assert property (@(posedge ref_clk) disable iff (srst)
        1'b1 |=> device_sleep == $past(sleep_r))
        else $error("sleep output does not follow its bit");
    chk_bypass_pair: assert property (@(posedge ref_clk) disable iff (srst)
        dbl_r && !sleep_r |=> ref_doubler_enable && loop2_div_bypass)
        else $error("doubler set but divider not bypassed");
    chk_dbl_off: assert property (@(posedge ref_clk) disable iff (srst)
        !dbl_r |=> !ref_doubler_enable && !loop2_div_bypass)
        else $error("divider bypassed with doubler bit low");
    chk_dbl_reset: assert property (@(posedge ref_clk) disable iff (srst)
        $fell(srst) |-> !dbl_r)
        else $error("doubler enable not low after reset");

    // Loop two filter selections and the invalid-code flag
    chk_res_flag: assert property (@(posedge ref_clk) disable iff (srst)
        res3_r > RES_MAX_CODE |=> code_invalid)
        else $error("invalid resistor three code unflagged");
    chk_res_four_flag: assert property (@(posedge ref_clk) disable iff (srst)
        res4_r > RES_MAX_CODE |=> code_invalid)
        else $error("invalid resistor four code unflagged");
    chk_res_copy: assert property (@(posedge ref_clk) disable iff (srst)
        1'b1 |=> filter_res_three_sel == $past(res3_r))
        else $error("resistor three output does not follow the field");
    chk_res_four_copy: assert property (@(posedge ref_clk) disable iff (srst)
        1'b1 |=> filter_res_four_sel == $past(res4_r))
        else $error("resistor four output does not follow the field");
    chk_cap_flag: assert property (@(posedge ref_clk) disable iff (srst)
        cap_r > CAP_MAX_CODE |=> code_invalid)
        else $error("reserved capacitor code unflagged");
    chk_cap_copy: assert property (@(posedge ref_clk) disable iff (srst)
        1'b1 |=> filter_cap_pair_sel == $past(cap_r))
        else $error("capacitor output does not follow the field");
    chk_flag_clear: assert property (@(posedge ref_clk) disable iff (srst)
        !bad_code |=> !code_invalid)
        else $error("flag raised with every code valid");
endmodule : plc_loop_config

// ===== tb/plc_wb_master.sv
// Controller model: programs the block over a classic Wishbone master port.
// Assumes a slave that acks each request once and drops ack the cycle after.
`timescale 1ns/1ps
module plc_wb_master #(
    parameter int REF_IN_MHZ = 25
)(
    input  wire logic                        ref_clk,
    input  wire logic                        wb_ack_o,
    output logic                             wb_cyc,
    output logic                             wb_stb,
    output logic                             wb_we,
    output logic [plc_pkg::ADDR_W-1:0]       wb_adr,
    output logic [31:0]                      wb_dat,
    output logic [3:0]                       wb_sel
);
    import plc_pkg::*;
    bit strict = 1'b1;
    initial {wb_cyc, wb_stb, wb_we, wb_adr, wb_dat, wb_sel} = '0;
    function automatic bit bad_code(logic [7:0] a, logic [31:0] d);
        return (a == OFF_LOOP1 && d[2:0] < PUMP_MIN_CODE) || (a == OFF_FILTER &&
            (d[2:0] > RES_MAX_CODE || d[6:4] > RES_MAX_CODE || d[11:8] > CAP_MAX_CODE));
    endfunction : bad_code
    // Request held until ack is sampled, so no fixed latency is assumed
    task automatic cycle(input logic w, input logic [7:0] a, input logic [31:0] d,
                         input logic [3:0] s);
        if (w && strict && bad_code(a, d)) return;
        if (w && a == OFF_CTRL && REF_IN_MHZ >= 50) d[POS_DOUBLER] = 1'b0;
        @(posedge ref_clk);
        {wb_cyc, wb_stb, wb_we, wb_adr, wb_dat, wb_sel} <= {2'b11, w, a, d, s};
        @(posedge ref_clk);
        // No own limit: only the bench watchdog ends a hung wait
        while (wb_ack_o !== 1'b1) begin
            @(posedge ref_clk);
        end
        {wb_cyc, wb_stb, wb_we} <= 3'h0;
        @(posedge ref_clk);
    endtask : cycle
endmodule : plc_wb_master

// ===== tb/pll_loop_config_control_tb_top.sv
// Self-checking bench for the loop configuration block.
// Assumes the controller model drives the bus; a monitor checks read data.
`timescale 1ns/1ps
module pll_loop_config_control_tb_top;
    import plc_pkg::*;
    logic ref_clk = 1'b0, srst = 1'b1, pin = 1'b1;
    logic cyc, stb, we, ack, sl, xt, ax, clk_on, dbl, byp, inv, pol_o;
    logic [7:0] adr;
    logic [31:0] dw, dr;
    logic [3:0] sel, cap;
    logic [2:0] psel, r3, r4;
    logic [8:0] ua;
    logic [31:0] exp_q[$];
    int fail_count = 0, n_compared = 0;
    logic [8:0] ua_tab[8] = '{9'h000, 9'h000, 9'h014, 9'h050, 9'h019, 9'h032, 9'h064, 9'h190};
    plc_wb_master u_host (.ref_clk(ref_clk), .wb_ack_o(ack), .wb_cyc(cyc), .wb_stb(stb),
        .wb_we(we), .wb_adr(adr), .wb_dat(dw), .wb_sel(sel));
    plc_loop_config DUT (.ref_clk(ref_clk), .srst(srst), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(dw), .wb_sel_i(sel), .wb_dat_o(dr),
        .wb_ack_o(ack), .output_enable_pin(pin), .loop1_pump_current_sel(psel),
        .loop1_pump_ua(ua), .loop1_pump_polarity(pol_o), .crystal_amp_enable(xt),
        .aux_out_enable(ax), .out_clocks_run(clk_on), .device_sleep(sl),
        .ref_doubler_enable(dbl), .loop2_div_bypass(byp), .filter_res_three_sel(r3),
        .filter_res_four_sel(r4), .filter_cap_pair_sel(cap), .code_invalid(inv));
    initial forever #25 ref_clk = ~ref_clk;
    task automatic print_verdict();
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : print_verdict
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    // Derived outputs lag the register by a cycle; the idle cycle covers it
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
        u_host.cycle(1'b1, a, d, s);
        #1;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        u_host.cycle(1'b0, a, 32'h0, 4'hf);
    endtask : rd
    always @(posedge ref_clk) begin
        if (ack === 1'b1 && we === 1'b0) begin
            if (exp_q.size() == 0) chk("stray ack", 32'h1, 32'h0);
            else chk("read data", exp_q.pop_front(), dr);
        end
    end
    initial begin
        repeat (5000) @(posedge ref_clk);
        fail_count++;
        print_verdict();
    end
    initial begin
        logic p, g, s;
        logic [31:0] f;
        void'($urandom(79));
        repeat (6) @(posedge ref_clk);
        srst <= 1'b0;
        repeat (2) @(posedge ref_clk);
        #1;
        chk("pump ua", 32'h14, ua);
        chk("aux", 32'h0, ax);
        chk("doubler", 32'h0, dbl);
        chk("clocks", 32'h1, clk_on);
        rd(OFF_CTRL, 32'h00040000);
        rd(OFF_STATUS, 32'h6);
        u_host.strict = 1'b0;
        for (int c = 0; c < 8; c++) begin
            p = 1'($urandom);
            wr(OFF_LOOP1, {28'h0, p, 3'(c)}, 4'h1);
            chk("pump ua", ua_tab[c], ua);
            chk("polarity", p, pol_o);
            chk("pump code", c, psel);
            chk("flag", c < 2, inv);
        end
        for (int i = 0; i < 7; i++) begin
            f = {20'h0, 4'($urandom), 1'b0, 3'($urandom), 1'b0, 3'($urandom)};
            if (i == 6) f = 32'h00000b44;
            wr(OFF_FILTER, f, 4'h3);
            chk("res three", f[2:0], r3);
            chk("res four", f[6:4], r4);
            chk("cap", f[11:8], cap);
            chk("flag", f[2:0] > 4 || f[6:4] > 4 || f[11:8] > 11, inv);
            rd(OFF_FILTER, f);
        end
        for (int m = 0; m < 16; m++) begin
            g = 1'($urandom);
            @(posedge ref_clk);
            pin <= 1'($urandom);
            wr(OFF_CTRL, {13'h0, g, 14'h0, 4'(m)}, 4'h5);
            s = m[2];
            chk("xtal", m[0] & !s, xt);
            chk("aux", m[1] & !s, ax);
            chk("sleep", s, sl);
            chk("doubler", m[3] & !s, dbl);
            chk("bypass", m[3] & !s, byp);
            chk("clocks", g & pin & !s, clk_on);
            chk("pump ua", s ? 32'h0 : 32'h190, ua);
            rd(OFF_STATUS, {29'h0, !s, g & pin & !s, 1'b0});
        end
        wr(OFF_CTRL, 32'h0, 4'h0);
        chk("masked lane", 32'h1, sl);
        wr(OFF_CTRL, 32'h0, 4'h1);
        rd(OFF_CTRL, {13'h0, g, 18'h0});
        wr(8'h10, 32'hffffffff, 4'hf);
        rd(8'h10, 32'h0);
        rd(OFF_LOOP1, {28'h0, p, 3'h7});
        chk("pending reads", 32'h0, exp_q.size());
        print_verdict();
    end
endmodule : pll_loop_config_control_tb_top
